//--- hw/msc_pkg.sv
// constants, types and reset state of the motor speed-command front end
// assumes one 10 MHz core clock and a plain address/strobe register port
//
// Overview of operation
// - one of four sources feeds duty command
// - loop on: full command gives full-scale speed
// - loop on: low command held at floor speed
// - loop off: target duty linear, floor clamped
// - command under stop threshold zeroes and stops
// - output settles on target; ramp shapes transients
// - source 00 selects analog level
// - analog: zero, linear, then saturate at full
// - source 01 selects pulse duty
// - pulse mode: command linear in input duty
// - pulse mode: long low input stops motor
// - input band selectable, independent of output
// - source 10 takes host command directly
// - host mode: low input, zero command, sleep
// - host mode: input above exit leaves sleep
// - host mode: high input, zero command, standby
// - source 11 selects input frequency
// - frequency above full scale saturates command
// - frequency mode: long low input stops motor
// - nonzero target starts motor, zero keeps idle
package msc_pkg;

  localparam int         DUTY_W    = 10;
  localparam logic [9:0] DUTY_FULL = 10'h3ff;

  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_HOST   = 8'h04;
  localparam logic [7:0] A_LIMIT  = 8'h08;
  localparam logic [7:0] A_MAXSPD = 8'h0c;
  localparam logic [7:0] A_ANALOG = 8'h10;
  localparam logic [7:0] A_FSPER  = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;

  // field positions
  localparam int CTRL_SRC   = 0;
  localparam int CTRL_LOOP  = 2;
  localparam int CTRL_BAND  = 3;
  localparam int CTRL_SURGE = 5;
  localparam int CTRL_ACC   = 8;
  localparam int LIM_MIN    = 0;
  localparam int LIM_STOP   = 16;
  localparam int ANA_STOP   = 0;
  localparam int ANA_FS     = 16;
  localparam int ST_RUN     = 10;
  localparam int ST_SLEEP   = 11;
  localparam int ST_STBY    = 12;
  localparam int ST_IDLE    = 13;
  localparam int ST_SPEED   = 16;

  // reset values
  localparam logic [9:0]  RST_MIN    = 10'h033;
  localparam logic [9:0]  RST_STOP   = 10'h01a;
  localparam logic [15:0] RST_MAXSPD = 16'h03e8;
  localparam logic [11:0] RST_ASTOP  = 12'h0ff;
  localparam logic [11:0] RST_AFS    = 12'hf00;
  localparam logic [15:0] RST_FSPER  = 16'h00c8;
  localparam logic [3:0]  RST_ACC    = 4'h1;

  // timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int PULSE_IDLE_MS  = 10;
  localparam int FREQ_IDLE_MS   = 10;
  localparam int SLEEP_DELAY_MS = 20;
  localparam int RAMP_US        = 100;
  localparam int PULSE_IDLE_CYC = PULSE_IDLE_MS * (CLK_HZ / 1000);
  localparam int FREQ_IDLE_CYC  = FREQ_IDLE_MS * (CLK_HZ / 1000);
  localparam int SLEEP_CYC      = SLEEP_DELAY_MS * (CLK_HZ / 1000);
  localparam int RAMP_CYC       = RAMP_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00,
    SRC_PULSE  = 2'b01,
    SRC_HOST   = 2'b10,
    SRC_FREQ   = 2'b11
  } msc_src_t;

  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_SLEEP   = 2'b01,
    PWR_RUN     = 2'b10
  } msc_pwr_t;

  typedef struct packed {
    logic [15:0] speed_ref;
    logic [9:0]  target_duty;
    logic [9:0]  duty_out;
    logic        running;
    logic        sleep;
    logic        standby;
  } msc_out_t;

  typedef struct packed {
    logic [1:0]  pin_s;
    logic [1:0]  ent_s;
    logic [1:0]  ext_s;
    logic        pin_q;
    msc_src_t    src;
    logic        loop_en;
    logic [1:0]  band;
    logic        surge_en;
    logic [3:0]  acc;
    logic [9:0]  host_cmd;
    logic [9:0]  min_duty;
    logic [9:0]  stop_thr;
    logic [15:0] max_speed;
    logic [11:0] ana_stop;
    logic [11:0] ana_fs;
    logic [15:0] fs_per;
    logic [31:0] rdata;
    logic [5:0]  pre;
    logic [15:0] per_cnt;
    logic [15:0] hi_cnt;
    logic [19:0] idle_cnt;
    logic        idle;
    logic        busy;
    msc_src_t    div_src;
    logic [3:0]  div_n;
    logic [16:0] rem;
    logic [15:0] den;
    logic [9:0]  quo;
    logic [9:0]  duty_cmd;
    logic [19:0] sleep_cnt;
    msc_pwr_t    pwr;
    logic [9:0]  ramp_cnt;
    msc_out_t    o;
  } msc_state_t;

  localparam msc_state_t ST_RST = '{
    src: SRC_ANALOG, div_src: SRC_ANALOG, pwr: PWR_STANDBY,
    min_duty: RST_MIN, stop_thr: RST_STOP, max_speed: RST_MAXSPD,
    ana_stop: RST_ASTOP, ana_fs: RST_AFS, fs_per: RST_FSPER,
    acc: RST_ACC, o: '{standby: 1'b1, default: '0}, default: '0};

endpackage

//--- hw/msc_frontend.sv
// speed-command front end: source select, measurement, duty mapping,
// output ramp and sleep/standby control
// assumes speed pin and level comparators are asynchronous; adc word
// and register port are synchronous to sys_clk
`timescale 1ns/1ps
module msc_frontend
  import msc_pkg::*;
#(
  parameter int PULSE_IDLE = PULSE_IDLE_CYC,
  parameter int FREQ_IDLE  = FREQ_IDLE_CYC,
  parameter int SLEEP_DLY  = SLEEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [31:0] reg_rdata,
  input  wire logic        speed_pin,
  input  wire logic        speed_below_entry,
  input  wire logic        speed_above_exit,
  input  wire logic [11:0] adc_level,
  input  wire logic        adc_valid,
  output      msc_out_t    cmd_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  function automatic logic [15:0] scale_speed(logic [9:0] d,
                                              logic [15:0] m);
    logic [25:0] p;
    p = 26'(d) * 26'(m);
    return (d == DUTY_FULL) ? m : p[25:10];
  endfunction

  // prescale mask per input band; wider bands tick less often and shrink the period count
  function automatic logic [5:0] band_mask(logic [1:0] b);
    case (b)
      2'b00:   band_mask = 6'h00;
      2'b01:   band_mask = 6'h03;
      2'b10:   band_mask = 6'h0f;
      default: band_mask = 6'h3f;
    endcase
  endfunction

  msc_state_t st;
  msc_state_t next_st;

  logic        tick;
  logic        rise;
  logic        meas_mode;
  logic [19:0] idle_lim;
  logic [9:0]  clamped;
  logic [16:0] shifted;
  logic [9:0]  diff;
  logic [9:0]  step;
  logic [9:0]  ramp_goal;

  ////////////////////////////////////////////////////////////////////////
  // all next-state logic
  always_comb begin
    next_st   = st;
    clamped   = '0;
    shifted   = '0;
    diff      = '0;
    step      = '0;
    ramp_goal = '0;

    // two-flop synchronisers for every pin-derived level
    next_st.pin_s = {st.pin_s[0], speed_pin};
    next_st.ent_s = {st.ent_s[0], speed_below_entry};
    next_st.ext_s = {st.ext_s[0], speed_above_exit};
    next_st.pin_q = st.pin_s[1];

    // register writes; unmapped addresses are ignored
    if (reg_wr) begin
      case (reg_addr)
        A_CTRL: begin
          next_st.src      = msc_src_t'(reg_wdata[CTRL_SRC +: 2]);
          next_st.loop_en  = reg_wdata[CTRL_LOOP];
          next_st.band     = reg_wdata[CTRL_BAND +: 2];
          next_st.surge_en = reg_wdata[CTRL_SURGE];
          next_st.acc      = reg_wdata[CTRL_ACC +: 4];
        end
        A_HOST:   next_st.host_cmd  = reg_wdata[9:0];
        A_LIMIT: begin
          next_st.min_duty = reg_wdata[LIM_MIN +: 10];
          next_st.stop_thr = reg_wdata[LIM_STOP +: 10];
        end
        A_MAXSPD: next_st.max_speed = reg_wdata[15:0];
        A_ANALOG: begin
          next_st.ana_stop = reg_wdata[ANA_STOP +: 12];
          next_st.ana_fs   = reg_wdata[ANA_FS +: 12];
        end
        A_FSPER:  next_st.fs_per    = reg_wdata[15:0];
        default:  next_st.fs_per    = st.fs_per;
      endcase
    end

    // read data stands one cycle after the strobe, zero elsewhere
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: next_st.rdata = {20'h0, st.acc, 2'b00, st.surge_en,
                                 st.band, st.loop_en, st.src};
        A_HOST:   next_st.rdata = {22'h0, st.host_cmd};
        A_LIMIT:  next_st.rdata = {6'h0, st.stop_thr, 6'h0, st.min_duty};
        A_MAXSPD: next_st.rdata = {16'h0, st.max_speed};
        A_ANALOG: next_st.rdata = {4'h0, st.ana_fs, 4'h0, st.ana_stop};
        A_FSPER:  next_st.rdata = {16'h0, st.fs_per};
        A_STATUS: next_st.rdata = {st.o.speed_ref, 2'b00, st.idle,
                                   st.o.standby, st.o.sleep,
                                   st.o.running, st.duty_cmd};
        default:  next_st.rdata = '0;
      endcase
    end

    // band prescaler: one-cycle enable that paces the period counters
    next_st.pre = st.pre + 6'h01;
    tick = (st.pre & band_mask(st.band)) == 6'h00;
    rise = st.pin_s[1] & ~st.pin_q;
    meas_mode = (st.src == SRC_PULSE) || (st.src == SRC_FREQ);

    if (tick) begin
      if (st.per_cnt != 16'hffff) begin
        next_st.per_cnt = st.per_cnt + 16'h0001;
      end
      if (st.pin_s[1] && st.hi_cnt != 16'hffff) begin
        next_st.hi_cnt = st.hi_cnt + 16'h0001;
      end
    end

    // low-level watchdog on the speed input
    idle_lim = (st.src == SRC_PULSE) ? 20'(PULSE_IDLE) : 20'(FREQ_IDLE);
    if (st.pin_s[1]) begin
      next_st.idle_cnt = '0;
    end else if (st.idle_cnt != 20'hfffff) begin
      next_st.idle_cnt = st.idle_cnt + 20'h00001;
    end
    next_st.idle = meas_mode && (st.idle_cnt >= idle_lim);

    // a completed period starts one division or sets a full command directly; an overflowed or busy
    // period is dropped and the old command is held
    // the rise cycle opens the new period, so its own tick counts there;
    // dropping it would shave one tick off every measured period
    if (rise) begin
      next_st.per_cnt = {15'h0, tick};
      next_st.hi_cnt  = {15'h0, tick};
      if (meas_mode && !st.busy && st.per_cnt != 16'h0000 &&
          st.per_cnt != 16'hffff) begin
        if (st.src == SRC_PULSE) begin
          if (st.hi_cnt >= st.per_cnt) begin
            next_st.duty_cmd = DUTY_FULL;
          end else begin
            next_st.busy = 1'b1;
            next_st.rem  = {1'b0, st.hi_cnt};
            next_st.den  = st.per_cnt;
          end
        end else if (st.per_cnt <= st.fs_per) begin
          next_st.duty_cmd = DUTY_FULL;
        end else begin
          next_st.busy = 1'b1;
          next_st.rem  = {1'b0, st.fs_per};
          next_st.den  = st.per_cnt;
        end
        next_st.div_src = st.src;
        next_st.div_n   = '0;
        next_st.quo     = '0;
      end
    end

    // analog sample: zero, linear span, then saturate
    if (st.src == SRC_ANALOG && adc_valid && !st.busy) begin
      if (adc_level <= st.ana_stop) begin
        next_st.duty_cmd = '0;
      end else if (adc_level >= st.ana_fs) begin
        next_st.duty_cmd = DUTY_FULL;
      end else begin
        next_st.busy    = 1'b1;
        next_st.rem     = {5'h0, adc_level - st.ana_stop};
        next_st.den     = {4'h0, st.ana_fs - st.ana_stop};
        next_st.div_src = SRC_ANALOG;
        next_st.div_n   = '0;
        next_st.quo     = '0;
      end
    end

    // serial fraction divider, ten result bits, one bit per cycle;
    // slower than a combinational divider but far smaller
    if (st.busy) begin
      shifted = {st.rem[15:0], 1'b0};
      if (shifted >= {1'b0, st.den}) begin
        next_st.rem = shifted - {1'b0, st.den};
        next_st.quo = {st.quo[8:0], 1'b1};
      end else begin
        next_st.rem = shifted;
        next_st.quo = {st.quo[8:0], 1'b0};
      end
      next_st.div_n = st.div_n + 4'h1;
      if (st.div_n == 4'h9) begin
        next_st.busy = 1'b0;
        if (st.div_src == st.src) begin
          next_st.duty_cmd = next_st.quo;
        end
      end
    end

    // host command goes straight through; idle input forces a stop
    if (st.src == SRC_HOST) begin
      next_st.duty_cmd = st.host_cmd;
    end else if (st.idle) begin
      next_st.duty_cmd = '0;
    end

    // map duty command onto speed reference or target duty
    clamped = (st.duty_cmd < st.min_duty) ? st.min_duty : st.duty_cmd;
    if (st.duty_cmd < st.stop_thr) begin
      next_st.o.target_duty = '0;
      next_st.o.speed_ref   = '0;
    end else begin
      next_st.o.target_duty = clamped;
      next_st.o.speed_ref   = st.loop_en ?
                              scale_speed(clamped, st.max_speed) :
                              16'h0000;
    end

    // sleep delay counts only with host mode, zero command, low input
    if (st.src == SRC_HOST && st.host_cmd == 10'h000 && st.ent_s[1]) begin
      if (st.sleep_cnt != 20'hfffff) begin
        next_st.sleep_cnt = st.sleep_cnt + 20'h00001;
      end
    end else begin
      next_st.sleep_cnt = '0;
    end

    // power state: a nonzero target wakes the motor start sequence
    case (st.pwr)
      PWR_RUN: begin
        if (st.o.target_duty == 10'h000) begin
          next_st.pwr = PWR_STANDBY;
        end
      end
      PWR_STANDBY: begin
        if (st.o.target_duty != 10'h000) begin
          next_st.pwr = PWR_RUN;
        end else if (st.sleep_cnt >= 20'(SLEEP_DLY)) begin
          next_st.pwr = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (st.o.target_duty != 10'h000) begin
          next_st.pwr = PWR_RUN;
        end else if (st.ext_s[1]) begin
          next_st.pwr = PWR_STANDBY;
        end
      end
      default: next_st.pwr = PWR_STANDBY;
    endcase
    next_st.o.running = next_st.pwr == PWR_RUN;
    next_st.o.sleep   = next_st.pwr == PWR_SLEEP;
    next_st.o.standby = next_st.pwr == PWR_STANDBY;

    // output ramp: steady value is the target, slope set by acc;
    // surge guard slows falls so braking energy stays small
    ramp_goal = (st.pwr == PWR_RUN) ? st.o.target_duty : 10'h000;
    if (st.ramp_cnt >= 10'(RAMP_CYC - 1)) begin
      next_st.ramp_cnt = '0;
      if (st.o.duty_out < ramp_goal) begin
        diff = ramp_goal - st.o.duty_out;
        step = (diff < {6'h0, st.acc}) ? diff : {6'h0, st.acc};
        next_st.o.duty_out = st.o.duty_out + step;
      end else if (st.o.duty_out > ramp_goal) begin
        diff = st.o.duty_out - ramp_goal;
        step = st.surge_en ? 10'h001 : {6'h0, st.acc};
        step = (diff < step) ? diff : step;
        next_st.o.duty_out = st.o.duty_out - step;
      end
    end else begin
      next_st.ramp_cnt = st.ramp_cnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign cmd_out   = st.o;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_host_direct: assert property (
    st.src == SRC_HOST |=> st.duty_cmd == $past(st.host_cmd))
    else $error("host command not passed through");

  a_stop_zero: assert property (
    st.duty_cmd < st.stop_thr |=>
      st.o.target_duty == 10'h000 && st.o.speed_ref == 16'h0000)
    else $error("stop threshold did not zero the outputs");

  a_floor_duty: assert property (
    st.duty_cmd >= st.stop_thr && st.duty_cmd < st.min_duty |=>
      st.o.target_duty == $past(st.min_duty))
    else $error("target duty not clamped to floor");

  a_floor_speed: assert property (
    st.loop_en && st.duty_cmd >= st.stop_thr &&
    st.duty_cmd < st.min_duty |=>
      st.o.speed_ref == scale_speed($past(st.min_duty),
                                    $past(st.max_speed)))
    else $error("speed reference not clamped to floor");

  a_full_speed: assert property (
    st.loop_en && st.duty_cmd == DUTY_FULL &&
    st.stop_thr <= DUTY_FULL |=> st.o.speed_ref == $past(st.max_speed))
    else $error("full command did not give full speed");

  a_idle_stop: assert property (
    st.idle && st.src != SRC_HOST |=> st.duty_cmd == 10'h000)
    else $error("idle input did not stop the command");

  a_sleep_exit: assert property (
    st.pwr == PWR_SLEEP && st.ext_s[1] |=> st.pwr != PWR_SLEEP)
    else $error("sleep not left above exit level");

  a_start_run: assert property (
    st.pwr != PWR_RUN && st.o.target_duty != 10'h000 |=>
      st.pwr == PWR_RUN && st.o.running)
    else $error("nonzero target did not start the motor");

  a_sleep_entry: assert property (
    st.pwr == PWR_SLEEP |-> $past(st.sleep_cnt) >= 20'(SLEEP_DLY) ||
      $past(st.pwr) == PWR_SLEEP)
    else $error("sleep entered before the delay");

  a_div_bound: assert property (
    $rose(st.busy) |-> st.div_n == 4'h0 ##9
      st.busy && st.div_n == 4'h9 ##1 !st.busy)
    else $error("division not ten cycles long");

  a_ramp_hold: assert property (
    st.pwr == PWR_RUN && st.o.duty_out == st.o.target_duty ##1
      $stable(st.o.target_duty) && st.pwr == PWR_RUN |->
      $stable(st.o.duty_out))
    else $error("output moved off a steady target");

  c_pulse_div: cover property (st.div_src == SRC_PULSE && $fell(st.busy));
  c_freq_full: cover property (st.src == SRC_FREQ &&
                               st.duty_cmd == DUTY_FULL);
  c_sleep:     cover property (st.pwr == PWR_SLEEP ##1 st.pwr == PWR_RUN);
  c_idle:      cover property (st.src == SRC_PULSE && $rose(st.idle));

endmodule

//--- sim/msc_speed_src.sv
// far-side signal source for the speed pin: a square wave of set high and
// low lengths in sys_clk cycles, idle low while disabled
// assumes the bench changes hi/lo only while the source is disabled
`timescale 1ns/1ps
module msc_speed_src (
  input  wire logic        sys_clk,
  input  wire logic        en,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] lo_cyc,
  output      logic        speed_pin
);
  ////////////////////////////////////////////////////////////////////////
  // wave generator; idle low is what the stop timeouts look for
  initial begin
    speed_pin = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (en) begin
        speed_pin <= 1'b1;
        repeat (hi_cyc) @(posedge sys_clk);
        speed_pin <= 1'b0;
        repeat (lo_cyc - 16'h0001) @(posedge sys_clk);
      end
    end
  end
endmodule

//--- sim/motor_speed_command_frontend_tb.sv
// self-checking bench of the speed-command front end
// assumes the short timeout parameters below and the register port of
// the package; the speed pin comes from msc_speed_src
`timescale 1ns/1ps
module motor_speed_command_frontend_tb;
  import msc_pkg::*;

  logic        sys_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic        speed_pin;
  logic        speed_below_entry;
  logic        speed_above_exit;
  logic [11:0] adc_level;
  logic        adc_valid;
  logic        src_en;
  msc_out_t    cmd_out;
  int          n_errors;
  int          n_compared;
  int          cyc;
  logic [7:0]  ra [7] = '{A_CTRL, A_HOST, A_LIMIT, A_MAXSPD, A_ANALOG,
                          A_FSPER, 8'h1c};
  logic [31:0] rv [7] = '{{20'h0, RST_ACC, 8'h0}, 32'h0,
                          {6'h0, RST_STOP, 6'h0, RST_MIN},
                          {16'h0, RST_MAXSPD},
                          {4'h0, RST_AFS, 4'h0, RST_ASTOP},
                          {16'h0, RST_FSPER}, 32'h0};

  ////////////////////////////////////////////////////////////////////////
  // short timeouts keep the idle and sleep waits within a few hundred cycles
  msc_frontend #(.PULSE_IDLE(50), .FREQ_IDLE(50), .SLEEP_DLY(80)) dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .speed_pin(speed_pin),
    .speed_below_entry(speed_below_entry),
    .speed_above_exit(speed_above_exit), .adc_level(adc_level),
    .adc_valid(adc_valid), .cmd_out(cmd_out));

  msc_speed_src src_u (
    .sys_clk(sys_clk), .en(src_en), .hi_cyc(16'h000a),
    .lo_cyc(16'h001e), .speed_pin(speed_pin));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the ceiling is well above the planned run
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic adc(input logic [11:0] lvl);
    @(posedge sys_clk);
    adc_level <= lvl;
    adc_valid <= 1'b1;
    @(posedge sys_clk);
    adc_valid <= 1'b0;
  endtask

  // bounded wait on target duty, then target and run state compared
  task automatic wait_tgt(input logic [9:0] exp);
    int i;
    for (i = 0; i < 400 && cmd_out.target_duty !== exp; i++) begin
      @(negedge sys_clk);
    end
    repeat (3) @(negedge sys_clk);
    check("target_duty", {22'h0, exp}, {22'h0, cmd_out.target_duty});
    check("running", {31'h0, exp != 10'h0}, {31'h0, cmd_out.running});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    speed_below_entry = 1'b0;
    speed_above_exit = 1'b1;
    adc_level = 12'h000;
    adc_valid = 1'b0;
    src_en = 1'b0;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], rd_val);
      check("reset register", rv[i], rd_val);
    end
    // analog source: saturate, stop level, then a mid-scale level
    adc(RST_AFS);
    wait_tgt(DUTY_FULL);
    adc(RST_ASTOP);
    wait_tgt(10'h000);
    wr(A_ANALOG, 32'h0400_0000);
    adc(12'h200);
    wait_tgt(10'h200);
    // host source, loop off: full, floor clamp, below stop
    wr(A_CTRL, 32'h0000_0102);
    wr(A_HOST, 32'h0000_03ff);
    wait_tgt(DUTY_FULL);
    wr(A_HOST, 32'h0000_0020);
    wait_tgt(RST_MIN);
    wr(A_HOST, 32'h0000_0010);
    wait_tgt(10'h000);
    // loop on: full scale speed and floor speed
    wr(A_CTRL, 32'h0000_0106);
    wr(A_HOST, 32'h0000_03ff);
    wait_tgt(DUTY_FULL);
    check("speed_ref", {16'h0, RST_MAXSPD}, {16'h0, cmd_out.speed_ref});
    rd(A_STATUS, rd_val);
    check("status", {RST_MAXSPD, 6'h01, DUTY_FULL}, rd_val);
    wr(A_HOST, 32'h0000_0020);
    wait_tgt(RST_MIN);
    check("speed_ref", (32'(RST_MIN) * 32'(RST_MAXSPD)) >> 10,
          {16'h0, cmd_out.speed_ref});
    // loop off, fast ramp: applied duty settles on target
    wr(A_CTRL, 32'h0000_0f02);
    wr(A_HOST, 32'h0000_0040);
    wait_tgt(10'h040);
    repeat (8000) @(posedge sys_clk);
    check("duty_out", 32'h40, {22'h0, cmd_out.duty_out});
    // surge guard: a fall moves one count per ramp tick, not acc counts
    wr(A_CTRL, 32'h0000_0f22);
    wr(A_HOST, 32'h0000_0036);
    wait_tgt(10'h036);
    repeat (3000) @(posedge sys_clk);
    check("surge fall", 32'h1, {31'h0, cmd_out.duty_out >= 10'h03a});
    // sleep entry only after the delay, exit to standby, wake on command
    wr(A_HOST, 32'h0);
    wait_tgt(10'h000);
    speed_above_exit <= 1'b0;
    speed_below_entry <= 1'b1;
    repeat (40) @(posedge sys_clk);
    check("early sleep", 32'h0, {31'h0, cmd_out.sleep});
    repeat (80) @(posedge sys_clk);
    check("sleep", 32'h1, {31'h0, cmd_out.sleep});
    speed_below_entry <= 1'b0;
    speed_above_exit <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("sleep left", 32'h0, {31'h0, cmd_out.sleep});
    check("standby", 32'h1, {31'h0, cmd_out.standby});
    wr(A_HOST, 32'h0000_03ff);
    wait_tgt(DUTY_FULL);
    // pulse source: 10 high of 40 gives a quarter, idle low stops
    wr(A_CTRL, 32'h0000_0101);
    src_en <= 1'b1;
    wait_tgt(10'h100);
    src_en <= 1'b0;
    wait_tgt(10'h000);
    // frequency source: half, saturate, slower band, idle low stops
    wr(A_FSPER, 32'h0000_0014);
    wr(A_CTRL, 32'h0000_0103);
    src_en <= 1'b1;
    wait_tgt(10'h200);
    wr(A_FSPER, 32'h0000_00c8);
    wait_tgt(DUTY_FULL);
    wr(A_FSPER, 32'h0000_0005);
    wr(A_CTRL, 32'h0000_010b);
    wait_tgt(10'h200);
    src_en <= 1'b0;
    wait_tgt(10'h000);
    finish_test();
  end
endmodule
